// [fob_regs.svh]
/*
  Offsets, field positions, reset values and timing counts of the fanout
  output-enable controller. Included by bare name by the design files.
*/
`ifndef FOB_REGS_SVH
`define FOB_REGS_SVH

// Register byte offsets on the Avalon-MM slave
`define FOB_OFS_MGMT_OE   6'h00
`define FOB_OFS_OUTCTL    6'h04
`define FOB_OFS_SHIFT     6'h08
`define FOB_OFS_STATE     6'h0c
`define FOB_OFS_IRQ_STAT  6'h10
`define FOB_OFS_IRQ_MASK  6'h14
`define FOB_OFS_ACTIVE    6'h18

// Reset values
`define FOB_MGMT_OE_RST   20'hfffff
`define FOB_OUTCTL_RST    20'hfffff
`define FOB_SHIFT_RST     20'h00000
`define FOB_IRQ_MASK_RST  3'h0

// Polarity: output 19 runs inverted against outputs 18..0
`define FOB_INVERT_MASK   20'h80000

// State register field positions
`define FOB_ST_SB_MODE    0
`define FOB_ST_STARTED    1
`define FOB_ST_PDOWN      2
`define FOB_ST_LOSS       3
`define FOB_ST_LOSS_PIN   4

// Loss-of-signal timeout; least time, rounded up to whole cycles
`define FOB_CLK_PERIOD_NS 25
`define FOB_LOS_TIME_NS   1000
`define FOB_LOS_CYCLES    ((`FOB_LOS_TIME_NS + `FOB_CLK_PERIOD_NS - 1) / `FOB_CLK_PERIOD_NS)
`define FOB_LOS_CNT_W     6

`endif

// [fob_pkg.sv]
/*
  Types of the fanout output-enable controller: power state, side-band
  pin group and interrupt event group. Assumes fob_regs.svh for numbers.
*/
package fob_pkg;

  typedef enum logic [1:0] {
    fob_st_wait  = 2'b00,
    fob_st_run   = 2'b01,
    fob_st_pdown = 2'b10
  } fob_state_t;

  typedef struct packed {
    logic serial_in;
    logic shift_clock;
    logic shift_load;
  } fob_sb_pins_t;

  typedef struct packed {
    logic pdown;
    logic load;
    logic loss;
  } fob_irq_t;

endpackage

// [fob_sync.sv]
/*
  Two-flop synchroniser for a vector of unrelated level inputs.
  Assumes each bit is an independent level; no bus coherency is given.
*/
`timescale 1ns/1ps
module fob_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// [fob_fanout_ctrl.sv]
/*
  Output-enable and side-band control of a twenty-output clock fanout
  buffer, with power sequencing, loss-of-signal flag and an Avalon-MM
  register slave. Assumes all pins are asynchronous to i_clk (40 MHz)
  and that the side-band shift clock runs well below a quarter of it.
*/
// Design decisions made here: the Avalon-MM register port and the address map.
// Functional notes
// - Strap 0: shared pins are enables; 1: side-band
// - Side-band keeps bus and dedicated enables working
// - Dedicated enable pins active low: 0 enables
// - Pin 5 shared: enable, or serial data in
// - Shift clock rising edge shifts data in
// - Shift-load low inhibits shifting, high allows
// - Shift-load falling edge copies shift register out
// - Shift register drives serial chain output
// - First power-good high samples strap, starts up
// - Low powers down; high resumes, no resample
// - Loss flag pulled low while reference absent
// - Output 19 polarity inverted against 18..0
`timescale 1ns/1ps
`include "fob_regs.svh"
module fob_fanout_ctrl (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Avalon-MM slave
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Straps and control pins
  input  wire logic        i_sideband_select_strap,
  input  wire logic        i_power_good_power_down_n,
  input  wire logic        i_reference_clock_in,
  // Enable pins, three of them shared with the side-band port
  input  wire logic        i_out5_enable_or_serial_in,
  input  wire logic        i_out6_enable_or_shift_clock,
  input  wire logic        i_out10_enable_or_shift_load,
  input  wire logic        i_output7_enable_n,
  input  wire logic        i_output8_enable_n,
  input  wire logic        i_output9_enable_n,
  input  wire logic        i_output11_enable_n,
  input  wire logic        i_output12_enable_n,
  // Open-drain loss flag
  input  wire logic        i_input_loss_flag_n,
  output logic             o_input_loss_flag_n,
  output logic             o_input_loss_flag_n_oe,
  // Clock path control and side-band chain
  output logic      [19:0] o_clk_enable,
  output logic      [19:0] o_clk_invert,
  output logic             o_serial_chain_out,
  // Interrupt
  output logic             o_irq
);

  localparam logic [`FOB_LOS_CNT_W-1:0] LOS_LIMIT = `FOB_LOS_CNT_W'(`FOB_LOS_CYCLES);

  logic [11:0]             pin_raw;
  logic [11:0]             pin_s;
  fob_pkg::fob_sb_pins_t   sb_now;
  fob_pkg::fob_sb_pins_t   sb_prev;
  fob_pkg::fob_state_t     st;
  fob_pkg::fob_state_t     next_st;
  fob_pkg::fob_irq_t       irq_stat;
  fob_pkg::fob_irq_t       irq_mask;
  fob_pkg::fob_irq_t       irq_ev;
  fob_pkg::fob_irq_t       irq_clr;
  logic                    strap_s;
  logic                    pg_s;
  logic                    ref_s;
  logic                    ref_prev;
  logic                    loss_pin_s;
  logic                    sb_mode;
  logic                    powered;
  logic                    shift_rise;
  logic                    load_fall;
  logic                    shift_go;
  logic [19:0]             shreg;
  logic [19:0]             outctl;
  logic [19:0]             mgmt_oe;
  logic [19:0]             pin_n;
  logic [19:0]             next_en;
  logic [`FOB_LOS_CNT_W-1:0] los_cnt;
  logic                    loss;
  logic                    ref_edge;
  logic                    ack;
  logic                    wr_acc;
  logic [23:0]             be_bits;
  logic [31:0]             next_rdata;

  // Every pin is asynchronous to i_clk
  assign pin_raw = {i_input_loss_flag_n, i_sideband_select_strap, i_power_good_power_down_n,
                    i_reference_clock_in, i_output12_enable_n, i_output11_enable_n,
                    i_out10_enable_or_shift_load, i_output9_enable_n, i_output8_enable_n,
                    i_output7_enable_n, i_out6_enable_or_shift_clock, i_out5_enable_or_serial_in};

  fob_sync #(
    .W (12)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (pin_raw),
    .o_sync  (pin_s)
  );

  assign loss_pin_s = pin_s[11];
  assign strap_s    = pin_s[10];
  assign pg_s       = pin_s[9];
  assign ref_s      = pin_s[8];
  assign sb_now     = '{serial_in: pin_s[0], shift_clock: pin_s[1], shift_load: pin_s[5]};

  // Power sequencing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= fob_pkg::fob_st_wait;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    next_st = st;
    case (st)
      fob_pkg::fob_st_wait: begin
        if (pg_s) begin
          next_st = fob_pkg::fob_st_run;
        end
      end
      fob_pkg::fob_st_run: begin
        if (!pg_s) begin
          next_st = fob_pkg::fob_st_pdown;
        end
      end
      fob_pkg::fob_st_pdown: begin
        if (pg_s) begin
          next_st = fob_pkg::fob_st_run;
        end
      end
      default: begin
        next_st = fob_pkg::fob_st_wait;
      end
    endcase
  end

  assign powered = (st == fob_pkg::fob_st_run);

  // Strap caught once at first power-good; later changes are ignored
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sb_mode <= 1'b0;
    end else if (st == fob_pkg::fob_st_wait && pg_s) begin
      sb_mode <= strap_s;
    end
  end

  // Side-band edge detection on the synchronised pins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sb_prev <= '0;
    end else begin
      sb_prev <= sb_now;
    end
  end

  assign shift_rise = sb_now.shift_clock && !sb_prev.shift_clock;
  assign load_fall  = !sb_now.shift_load && sb_prev.shift_load;
  assign shift_go   = sb_mode && sb_now.shift_load && shift_rise;

  // Shift register, bit 19 leaves first
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shreg <= `FOB_SHIFT_RST;
    end else if (shift_go) begin
      shreg <= {shreg[18:0], sb_now.serial_in};
    end
  end

  assign o_serial_chain_out = shreg[19];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      outctl <= `FOB_OUTCTL_RST;
    end else if (sb_mode && load_fall) begin
      outctl <= shreg;
    end
  end

  // Pin enables; shared pins stop gating once repurposed
  always_comb begin
    pin_n     = '0;
    pin_n[5]  = sb_mode ? 1'b0 : pin_s[0];
    pin_n[6]  = sb_mode ? 1'b0 : pin_s[1];
    pin_n[10] = sb_mode ? 1'b0 : pin_s[5];
    pin_n[7]  = pin_s[2];
    pin_n[8]  = pin_s[3];
    pin_n[9]  = pin_s[4];
    pin_n[11] = pin_s[6];
    pin_n[12] = pin_s[7];
  end

  for (genvar i = 0; i < 20; i++) begin : g_en
    assign next_en[i] = powered && !pin_n[i] && mgmt_oe[i] && (!sb_mode || outctl[i]);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_clk_enable <= '0;
    end else begin
      o_clk_enable <= next_en;
    end
  end

  assign o_clk_invert = `FOB_INVERT_MASK;

  // Loss detect; only edges seen by i_clk count, so the reference pin
  // here must be a divided or activity level below 20 MHz
  assign ref_edge = ref_s ^ ref_prev;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_prev <= 1'b0;
      los_cnt  <= '0;
      loss     <= 1'b0;
    end else begin
      ref_prev <= ref_s;
      if (ref_edge) begin
        los_cnt <= '0;
        loss    <= 1'b0;
      end else if (los_cnt != LOS_LIMIT) begin
        los_cnt <= los_cnt + 1'b1;
      end else begin
        loss <= 1'b1;
      end
    end
  end

  assign o_input_loss_flag_n    = 1'b0;
  assign o_input_loss_flag_n_oe = loss;

  // Avalon-MM: one wait state on every access
  assign o_avs_waitrequest = !ack;
  assign wr_acc  = i_avs_write && ack;
  assign be_bits = {{8{i_avs_byteenable[2]}}, {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_avs_read || i_avs_write) && !ack;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mgmt_oe <= `FOB_MGMT_OE_RST;
    end else if (wr_acc && i_avs_address == `FOB_OFS_MGMT_OE) begin
      mgmt_oe <= (mgmt_oe & ~be_bits[19:0]) | (i_avs_writedata[19:0] & be_bits[19:0]);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask <= `FOB_IRQ_MASK_RST;
    end else if (wr_acc && i_avs_address == `FOB_OFS_IRQ_MASK && i_avs_byteenable[0]) begin
      irq_mask <= i_avs_writedata[2:0];
    end
  end

  // Sticky events; a set in the clearing cycle survives
  assign irq_ev.loss  = !loss && !ref_edge && los_cnt == LOS_LIMIT;
  assign irq_ev.load  = sb_mode && load_fall;
  assign irq_ev.pdown = powered && !pg_s;
  assign irq_clr = (wr_acc && i_avs_address == `FOB_OFS_IRQ_STAT && i_avs_byteenable[0])
                   ? i_avs_writedata[2:0] : 3'h0;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
    end
  end

  assign o_irq = |(irq_stat & irq_mask);

  always_comb begin
    next_rdata = 32'h0;
    case (i_avs_address)
      `FOB_OFS_MGMT_OE:  next_rdata = {12'h0, mgmt_oe};
      `FOB_OFS_OUTCTL:   next_rdata = {12'h0, outctl};
      `FOB_OFS_SHIFT:    next_rdata = {12'h0, shreg};
      `FOB_OFS_STATE: begin
        next_rdata[`FOB_ST_SB_MODE]  = sb_mode;
        next_rdata[`FOB_ST_STARTED]  = (st != fob_pkg::fob_st_wait);
        next_rdata[`FOB_ST_PDOWN]    = (st == fob_pkg::fob_st_pdown);
        next_rdata[`FOB_ST_LOSS]     = loss;
        next_rdata[`FOB_ST_LOSS_PIN] = loss_pin_s;
      end
      `FOB_OFS_IRQ_STAT: next_rdata = {29'h0, irq_stat};
      `FOB_OFS_IRQ_MASK: next_rdata = {29'h0, irq_mask};
      `FOB_OFS_ACTIVE:   next_rdata = {12'h0, o_clk_enable};
      default:           next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs_read && !ack) begin
      o_avs_readdata <= next_rdata;
    end
  end

  // Checks
  property p_mux_as_enable;
    @(posedge i_clk) disable iff (!i_rst_n)
    (powered && !sb_mode) |=> o_clk_enable[6] == (!$past(pin_s[1]) && $past(mgmt_oe[6]));
  endproperty
  a_mux_as_enable: assert property (p_mux_as_enable) else $error("shared pin 6 not acting as enable");

  property p_sb_keeps_pins;
    @(posedge i_clk) disable iff (!i_rst_n)
    (powered && sb_mode && pin_s[2]) |=> !o_clk_enable[7];
  endproperty
  a_sb_keeps_pins: assert property (p_sb_keeps_pins) else $error("pin 7 ignored in side-band mode");

  property p_pin_active_low;
    @(posedge i_clk) disable iff (!i_rst_n)
    (powered && !pin_s[4] && mgmt_oe[9] && (!sb_mode || outctl[9])) |=> o_clk_enable[9];
  endproperty
  a_pin_active_low: assert property (p_pin_active_low) else $error("low pin 9 did not enable output");

  property p_shift_in;
    @(posedge i_clk) disable iff (!i_rst_n)
    (sb_mode && sb_now.shift_load && shift_rise) |=>
      shreg == {$past(shreg[18:0]), $past(sb_now.serial_in)} && o_serial_chain_out == $past(shreg[18]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift edge did not shift in data");

  property p_shift_inhibit;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!sb_now.shift_load || !sb_mode) |=> $stable(shreg);
  endproperty
  a_shift_inhibit: assert property (p_shift_inhibit) else $error("shift while load low");

  property p_load_copy;
    @(posedge i_clk) disable iff (!i_rst_n)
    (sb_mode && load_fall) |=> outctl == $past(shreg) ##1 (o_clk_enable & ~$past(outctl)) == 20'h0;
  endproperty
  a_load_copy: assert property (p_load_copy) else $error("load fall did not copy shift register");

  property p_startup;
    @(posedge i_clk) disable iff (!i_rst_n)
    (st == fob_pkg::fob_st_wait && pg_s) |=> powered && sb_mode == $past(strap_s);
  endproperty
  a_startup: assert property (p_startup) else $error("startup did not sample strap");

  property p_power_down;
    @(posedge i_clk) disable iff (!i_rst_n)
    (powered && !pg_s) |=> st == fob_pkg::fob_st_pdown && $stable(sb_mode) ##1 o_clk_enable == 20'h0;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down not entered");

  property p_loss_flag;
    @(posedge i_clk) disable iff (!i_rst_n)
    ref_edge |=> !o_input_loss_flag_n_oe [*8];
  endproperty
  a_loss_flag: assert property (p_loss_flag) else $error("loss flag set despite reference edge");

endmodule

// [fob_bmc_model.sv]
/*
  Board controller model driving the side-band serial port pins.
  Assumes the bench routes these pins onto the shared enable pins.
*/
`timescale 1ns/1ps
module fob_bmc_model (
  // Request
  input  wire logic          i_go,
  input  wire logic [19:0]   i_word,
  input  wire logic          i_slow,
  // Side-band pins and completion
  output fob_pkg::fob_sb_pins_t o_pins,
  output logic               o_done
);
  int h;
  initial begin
    o_pins = '0;
    o_done = 1'b0;
    forever begin
      @(posedge i_go);
      o_done = 1'b0;
      // Slow only stretches the lead-in; the shift clock period stays 200 ns
      h = i_slow ? 300 : 100;
      o_pins.shift_load = 1'b1;
      #(h);
      for (int i = 19; i >= 0; i--) begin
        o_pins.serial_in = i_word[i];
        #100;
        o_pins.shift_clock = 1'b1;
        #100;
        o_pins.shift_clock = 1'b0;
      end
      #100;
      o_pins.shift_load = 1'b0;
      // Pulled-down data line once released
      o_pins.serial_in = 1'b0;
      #100;
      o_done = 1'b1;
    end
  end
endmodule

// [test_fob_fanout_ctrl.sv]
/*
  Self-checking bench of the fanout controller: register bus, enable pins,
  side-band shifting, power states, interrupt and loss flag.
  Assumes fob_bmc_model and the design files are compiled first.
*/
`timescale 1ns/1ps
`include "fob_regs.svh"
module test_fob_fanout_ctrl;
  logic        clk, rst_n, rd, wr, pg, strap, ref_run, sb_use, go, slow;
  logic        ref_clk = 1'b0;
  logic [2:0]  rc = 3'h0;
  logic [5:0]  adr;
  logic [31:0] wd, seed, r;
  logic [3:0]  be;
  logic [2:0]  mux_n;
  logic [4:0]  ded_n;
  logic [19:0] word;
  wire  [31:0] rdata;
  wire  [19:0] en, inv;
  wire         wreq, loss_o, loss_oe, loss_pin, chain, irq, done;
  fob_pkg::fob_sb_pins_t sbp;
  logic [31:0] exp_q[$];
  int          miscompares, tests_run;

  assign loss_pin = loss_oe ? loss_o : 1'b1;

  fob_fanout_ctrl u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_sideband_select_strap(strap), .i_power_good_power_down_n(pg),
    .i_reference_clock_in(ref_clk), .i_out5_enable_or_serial_in(sb_use ? sbp.serial_in : mux_n[0]),
    .i_out6_enable_or_shift_clock(sb_use ? sbp.shift_clock : mux_n[1]),
    .i_out10_enable_or_shift_load(sb_use ? sbp.shift_load : mux_n[2]),
    .i_output7_enable_n(ded_n[0]), .i_output8_enable_n(ded_n[1]), .i_output9_enable_n(ded_n[2]),
    .i_output11_enable_n(ded_n[3]), .i_output12_enable_n(ded_n[4]), .i_input_loss_flag_n(loss_pin),
    .o_input_loss_flag_n(loss_o), .o_input_loss_flag_n_oe(loss_oe), .o_clk_enable(en),
    .o_clk_invert(inv), .o_serial_chain_out(chain), .o_irq(irq));

  fob_bmc_model u_bmc (.i_go(go), .i_word(word), .i_slow(slow), .o_pins(sbp), .o_done(done));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Slow activity on the reference, edges every 200 ns
  always @(posedge clk) begin
    rc <= rc + 3'h1;
    if (ref_run && rc == 3'h0) ref_clk <= ~ref_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [19:0] pin_mask(input logic sb);
    logic [19:0] m;
    m = 20'hfffff;
    m[7] = ~ded_n[0];
    m[8] = ~ded_n[1];
    m[9] = ~ded_n[2];
    m[11] = ~ded_n[3];
    m[12] = ~ded_n[4];
    if (!sb) begin
      m[5] = ~mux_n[0];
      m[6] = ~mux_n[1];
      m[10] = ~mux_n[2];
    end
    return m;
  endfunction

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One Avalon access; call right after a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] b,
                     input logic [31:0] e);
    int n;
    adr <= a;
    wd <= d;
    be <= b;
    if (w) wr <= 1'b1;
    else begin
      rd <= 1'b1;
      exp_q.push_back(e);
    end
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    if (n == 50) begin
      chk("waitrequest", 32'h0, 32'h1);
      test_done();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read results are judged where they appear
  always @(posedge clk) begin
    if (rd === 1'b1 && wreq === 1'b0) chk("readdata", exp_q.pop_front(), rdata);
  end

  initial begin
    rst_n = 1'b0; rd = 1'b0; wr = 1'b0; adr = 6'h00; wd = 32'h0; be = 4'hf; pg = 1'b0;
    strap = 1'b0; ref_run = 1'b1; sb_use = 1'b0; go = 1'b0; slow = 1'b0;
    mux_n = 3'h0; ded_n = 5'h00; word = 20'h0; seed = 32'd29422;
    miscompares = 0; tests_run = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("clk_enable", 32'h0, {12'h0, en});
    chk("clk_invert", {12'h0, `FOB_INVERT_MASK}, {12'h0, inv});
    bus(0, `FOB_OFS_MGMT_OE, 0, 4'hf, {12'h0, `FOB_MGMT_OE_RST});
    bus(0, `FOB_OFS_OUTCTL, 0, 4'hf, {12'h0, `FOB_OUTCTL_RST});
    bus(0, `FOB_OFS_SHIFT, 0, 4'hf, {12'h0, `FOB_SHIFT_RST});
    bus(0, `FOB_OFS_IRQ_MASK, 0, 4'hf, 32'h0);
    bus(1, `FOB_OFS_STATE, xs(), 4'hf, 0);
    bus(0, `FOB_OFS_STATE, 0, 4'hf, 32'h10);
    bus(1, 6'h1c, xs(), 4'hf, 0);
    bus(0, 6'h1c, 0, 4'hf, 32'h0);
    pg <= 1'b1;
    repeat (8) @(posedge clk);
    chk("clk_enable", 32'hfffff, {12'h0, en});
    mux_n <= 3'b101;
    ded_n <= 5'b00001;
    repeat (8) @(posedge clk);
    chk("clk_enable", {12'h0, pin_mask(0)}, {12'h0, en});
    r = xs();
    bus(1, `FOB_OFS_MGMT_OE, r, 4'hf, 0);
    bus(1, `FOB_OFS_MGMT_OE, 0, 4'h1, 0);
    repeat (4) @(posedge clk);
    bus(0, `FOB_OFS_MGMT_OE, 0, 4'hf, {12'h0, r[19:0] & 20'hfff00});
    bus(0, `FOB_OFS_ACTIVE, 0, 4'hf, {12'h0, r[19:0] & 20'hfff00 & pin_mask(0)});
    bus(1, `FOB_OFS_IRQ_STAT, 32'h7, 4'hf, 0);
    pg <= 1'b0;
    repeat (8) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    chk("clk_enable", 32'h0, {12'h0, en});
    bus(0, `FOB_OFS_STATE, 0, 4'hf, 32'h16);
    bus(1, `FOB_OFS_IRQ_MASK, 32'h4, 4'hf, 0);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1, `FOB_OFS_IRQ_STAT, 32'h4, 4'hf, 0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    pg <= 1'b1;
    repeat (8) @(posedge clk);
    bus(0, `FOB_OFS_STATE, 0, 4'hf, 32'h12);
    chk("clk_enable", {12'h0, r[19:0] & 20'hfff00 & pin_mask(0)}, {12'h0, en});
    pg <= 1'b0;
    rst_n <= 1'b0;
    // Strap only moves while the device is held in reset
    strap <= 1'b1;
    sb_use <= 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    pg <= 1'b1;
    repeat (8) @(posedge clk);
    bus(0, `FOB_OFS_STATE, 0, 4'hf, 32'h13);
    chk("clk_enable", {12'h0, pin_mask(1)}, {12'h0, en});
    bus(1, `FOB_OFS_IRQ_MASK, 32'h2, 4'hf, 0);
    for (int k = 0; k < 2; k++) begin
      word <= 20'(xs());
      slow <= k[0];
      go <= 1'b1;
      // Let the model drop the previous frame's done first
      @(posedge clk);
      for (r = 0; r < 2000 && done !== 1'b1; r++) @(posedge clk);
      if (r == 2000) begin
        chk("done", 32'h1, 32'h0);
        test_done();
      end
      go <= 1'b0;
      repeat (8) @(posedge clk);
      chk("irq load", 32'h1, {31'h0, irq});
      bus(0, `FOB_OFS_SHIFT, 0, 4'hf, {12'h0, word});
      chk("chain_out", {31'h0, word[19]}, {31'h0, chain});
      chk("clk_enable", {12'h0, word & pin_mask(1)}, {12'h0, en});
      bus(1, `FOB_OFS_IRQ_STAT, 32'h2, 4'hf, 0);
    end
    ref_run <= 1'b0;
    repeat (60) @(posedge clk);
    chk("loss_oe", 32'h1, {31'h0, loss_oe});
    bus(0, `FOB_OFS_STATE, 0, 4'hf, 32'h0b);
    ref_run <= 1'b1;
    repeat (30) @(posedge clk);
    chk("loss_oe", 32'h0, {31'h0, loss_oe});
    test_done();
  end
endmodule
